// ===== logic/servo_ramp_params.svh
// Register offsets, reset values and timing counts for the servo ramp block
`ifndef SERVO_RAMP_PARAMS_SVH
`define SERVO_RAMP_PARAMS_SVH
`define OFS_ACCEL 10'h144
`define OFS_DECEL 10'h146
`define OFS_SCURVE 10'h148
`define OFS_INERTIA 10'h14A
`define OFS_ZERO_SPEED_FLAG 10'h14C
`define OFS_TARGET_SPEED_REACHED 10'h14E
`define OFS_VFS 10'h150
`define OFS_TFS 10'h152
`define OFS_BRKON 10'h154
`define OFS_BRKOFF 10'h156
`define OFS_STOPSEL 10'h158
`define OFS_STATUS 10'h15A
`define OFS_LIMDEC 10'h15C
`define OFS_SPDTGT 10'h15E
`define RST_ACCEL 16'h00C8
`define RST_DECEL 16'h00C8
`define RST_SCURVE 16'h0000
`define RST_INERTIA 16'h000A
`define RST_ZERO_SPEED_FLAG 16'h0064
`define RST_TARGET_SPEED_REACHED 16'h0BB8
`define RST_VFS 16'h2711
`define RST_TFS 16'h0064
`define RST_BRKON 16'h0000
`define RST_BRKOFF 16'h0000
`define RST_STOPSEL 16'h0000
`define RST_LIMDEC 16'h00C8
`define ANALOG_RAMP_MAX 16'h4E20
`define ANALOG_SCURVE_MAX 16'h2710
`define INSTANT_STOP_MS 16'h0001
`define MS_PERIOD_NS 1000000
`define CLK_PERIOD_NS 10
`define MS_CYCLES (`MS_PERIOD_NS / `CLK_PERIOD_NS)
`define VOLT_FULL_SCALE 10
`endif

// ===== logic/servo_ramp_pkg.sv
// Types shared by the servo ramp block
package servo_ramp_pkg;
  typedef enum logic [1:0] {STOP_DYNAMIC, STOP_COAST, STOP_DYN_THEN_COAST, STOP_RSVD} stop_mode_e;
  typedef enum logic [1:0] {BRK_IDLE, BRK_ON_WAIT, BRK_RUN, BRK_OFF_WAIT} brake_state_e;
endpackage

// ===== logic/ms_tick.sv
// Millisecond timebase divider producing a one-cycle enable
`include "servo_ramp_params.svh"
module ms_tick
  import servo_ramp_pkg::*;
#(
  parameter int CYCLES = `MS_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  output logic tick
);
  logic [31:0] count_q;

  // Free-running divider; tick is registered, high in the cycle after the count reaches CYCLES-1
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_q <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else if (count_q == 32'(CYCLES - 1))
    begin
      count_q <= 32'h0000_0000;
      tick <= 1'b1;
    end
    else
    begin
      count_q <= count_q + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule

// ===== logic/servo_ramp_brake_status.sv
// Speed ramp, stop mode, analog scaling, speed flags and holding brake timing
// Summary of operation
// (R1) Servo-off or alarm stops motor per stop mode: dynamic, coast, dynamic-then-coast.
// (R2) Limit alarm with limit decel time of 1 ms stops motor instantly.
// (R3) Speed mode ramps zero to rated speed over acceleration time.
// (R4) Speed mode ramps rated speed to zero over deceleration time.
// (R5) Smoothing time 0 disables smoothing; ramp times still apply.
// (R6) With smoothing, total ramp time is ramp time plus smoothing time.
// (R7) Analog speed source forces smoothing to 0 and bypasses ramping.
// (R8) Analog source clamps acceleration and deceleration times to 20000 ms.
// (R9) Analog source clamps smoothing time to 10000 ms.
// (R10) Zero-speed flag set while speed magnitude is at or below threshold.
// (R11) Zero-speed flag stays set until speed rises above threshold.
// (R12) Target-reached set when speed magnitude reaches target speed setting.
// (R13) Target-reached held until speed drops below target speed setting.
// (R14) Analog speed value is voltage times speed full scale over 10.
// (R15) Scaled speed is command in speed mode, limit in torque mode.
// (R16) Analog torque is voltage times torque full scale over 10.
// (R17) After servo-on wait brake-on delay before activating brake output.
// (R18) After servo-off wait brake-off delay before deactivating brake output.
// (R19) During brake-off delay, engage brake early once below zero-speed threshold.
// (R20) Alarm or operational stop treats negative brake-off delay as zero.
// (R21) Ramp steps each millisecond by rated speed over ramp time, no overshoot.
//
// Decided for this implementation: strobed register access.
`include "servo_ramp_params.svh"
module servo_ramp_brake_status
  import servo_ramp_pkg::*;
#(
  parameter int MS_CYCLES = `MS_CYCLES,
  parameter int SPD_W = 16,
  parameter logic [15:0] RATED_RPM = 16'h0BB8
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [9:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  input wire logic servoOn,
  input wire logic alarmActive,
  input wire logic operational_stop,
  input wire logic forward_limit_alarm,
  input wire logic reverse_limit_alarm,
  input wire logic speedMode,
  input wire logic torqueMode,
  input wire logic analogSource,
  input wire logic signed [SPD_W-1:0] speedTarget,
  input wire logic signed [SPD_W-1:0] measSpeed,
  input wire logic [7:0] analogSpeedVolt,
  input wire logic [7:0] analogTorqueVolt,
  output logic signed [SPD_W-1:0] speedCmd,
  output logic [SPD_W-1:0] speedLimit,
  output logic [15:0] torqueValue,
  output logic [15:0] smoothEff,
  output logic dynBrake,
  output logic coastStop,
  output logic instantStop,
  output logic zero_speed_flag,
  output logic target_speed_reached,
  output logic holding_brake_output
);
  logic [15:0] accelQ, decelQ, scurveQ, inertiaQ, zspdQ, tspdQ, vfsQ, tfsQ;
  logic [15:0] brkOnQ, brkOffQ, stopSelQ, limDecQ;
  logic tick;
  logic [15:0] accelEff, decelEff, stepUp, stepDn;
  logic [31:0] speedScaled, torqueScaled;
  logic [SPD_W-1:0] speedMag;
  logic servoOn_q, stopping;
  // Brake sequencer state and its millisecond counter
  brake_state_e brk_q;
  logic [15:0] brkCnt_q;
  // Counter is 16 bits: exactly wide enough to reach the longest 16-bit brake delay

  // Saturating clamp used for analog limits
  function automatic logic [15:0] clampTo(input logic [15:0] v, input logic [15:0] mx);
    clampTo = (v > mx) ? mx : v;
  endfunction

  // Per-ms step: rated speed over ramp time, never zero so ramp always finishes
  function automatic logic [15:0] rampStep(input logic [16:0] t);
    logic [16:0] q;
    q = (t == 17'h0_0000) ? 17'(RATED_RPM) : 17'(RATED_RPM) / t;
    rampStep = (q == 17'h0_0000) ? 16'h0001 : q[15:0];
  endfunction

  // Magnitude of a signed speed
  function automatic logic [SPD_W-1:0] absSpeed(input logic signed [SPD_W-1:0] s);
    absSpeed = s[SPD_W-1] ? SPD_W'(-s) : SPD_W'(s);
  endfunction

  ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .tick(tick)
  );

  // Register writes; parameters take effect immediately
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      accelQ <= `RST_ACCEL;
      decelQ <= `RST_DECEL;
      scurveQ <= `RST_SCURVE;
      inertiaQ <= `RST_INERTIA;
      zspdQ <= `RST_ZERO_SPEED_FLAG;
      tspdQ <= `RST_TARGET_SPEED_REACHED;
      vfsQ <= `RST_VFS;
      tfsQ <= `RST_TFS;
      brkOnQ <= `RST_BRKON;
      brkOffQ <= `RST_BRKOFF;
      stopSelQ <= `RST_STOPSEL;
      limDecQ <= `RST_LIMDEC;
    end
    else if (regWr)
    begin
      unique case (regAddr)
        `OFS_ACCEL: accelQ <= regWrData;
        `OFS_DECEL: decelQ <= regWrData;
        `OFS_SCURVE: scurveQ <= regWrData;
        `OFS_INERTIA: inertiaQ <= regWrData;
        `OFS_ZERO_SPEED_FLAG: zspdQ <= regWrData;
        `OFS_TARGET_SPEED_REACHED: tspdQ <= regWrData;
        `OFS_VFS: vfsQ <= regWrData;
        `OFS_TFS: tfsQ <= regWrData;
        `OFS_BRKON: brkOnQ <= regWrData;
        `OFS_BRKOFF: brkOffQ <= regWrData;
        `OFS_STOPSEL: stopSelQ <= regWrData;
        `OFS_LIMDEC: limDecQ <= regWrData;
        // Status, readback and unmapped offsets ignore writes
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      regRdData <= 16'h0000;
    else if (regRd)
    begin
      unique case (regAddr)
        `OFS_ACCEL: regRdData <= accelQ;
        `OFS_DECEL: regRdData <= decelQ;
        `OFS_SCURVE: regRdData <= scurveQ;
        `OFS_INERTIA: regRdData <= inertiaQ;
        `OFS_ZERO_SPEED_FLAG: regRdData <= zspdQ;
        `OFS_TARGET_SPEED_REACHED: regRdData <= tspdQ;
        `OFS_VFS: regRdData <= vfsQ;
        `OFS_TFS: regRdData <= tfsQ;
        `OFS_BRKON: regRdData <= brkOnQ;
        `OFS_BRKOFF: regRdData <= brkOffQ;
        `OFS_STOPSEL: regRdData <= stopSelQ;
        `OFS_LIMDEC: regRdData <= limDecQ;
        `OFS_STATUS: regRdData <= {11'h000, holding_brake_output, instantStop, coastStop,
          target_speed_reached, zero_speed_flag};
        `OFS_SPDTGT: regRdData <= 16'(speedCmd);
        default: regRdData <= 16'h0000;
      endcase
    end
  end

  // Effective ramp settings; analog source clamps them
  always_comb
  begin
    accelEff = analogSource ? clampTo(accelQ, `ANALOG_RAMP_MAX) : accelQ; // R8
    decelEff = analogSource ? clampTo(decelQ, `ANALOG_RAMP_MAX) : decelQ; // R8
    // Clamp is moot since analog forces zero, but kept for readback consistency
    smoothEff = analogSource ? (clampTo(scurveQ, `ANALOG_SCURVE_MAX) & 16'h0000) : scurveQ; // R9 R7
    // Smoothing stretches each ramp by its own time; zero leaves ramps intact
    stepUp = rampStep(17'(accelEff) + 17'(smoothEff)); // R6 R5 R3
    stepDn = rampStep(17'(decelEff) + 17'(smoothEff)); // R6 R5 R4
  end

  // Analog scaling: volts in tenths of a volt times full scale over 10 V
  always_comb
  begin
    speedScaled = (32'(analogSpeedVolt) * 32'(vfsQ)) / 32'(`VOLT_FULL_SCALE * 10); // R14
    torqueScaled = (32'(analogTorqueVolt) * 32'(tfsQ)) / 32'(`VOLT_FULL_SCALE * 10); // R16
  end

  // Torque value and speed limit registered for glitch-free outputs
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      torqueValue <= 16'h0000;
      speedLimit <= '0;
    end
    else
    begin
      torqueValue <= torqueScaled[15:0]; // R16
      speedLimit <= torqueMode ? SPD_W'(speedScaled) : SPD_W'(RATED_RPM); // R15
    end
  end

  assign stopping = !servoOn || alarmActive || operational_stop;
  assign speedMag = absSpeed(measSpeed);

  // Stop behaviour; limit alarms with 1 ms decel stop instantly
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dynBrake <= 1'b0;
      coastStop <= 1'b0;
      instantStop <= 1'b0;
    end
    else
    begin
      instantStop <= (forward_limit_alarm || reverse_limit_alarm) &&
        (limDecQ == `INSTANT_STOP_MS); // R2
      if (!stopping)
      begin
        dynBrake <= 1'b0;
        coastStop <= 1'b0;
      end
      else
      begin
        unique case (stop_mode_e'(stopSelQ[1:0])) // R1
          STOP_DYNAMIC:
          begin
            dynBrake <= 1'b1;
            coastStop <= 1'b0;
          end
          STOP_COAST:
          begin
            dynBrake <= 1'b0;
            coastStop <= 1'b1;
          end
          STOP_DYN_THEN_COAST:
          begin
            dynBrake <= speedMag > SPD_W'(zspdQ / 16'h000A);
            coastStop <= speedMag <= SPD_W'(zspdQ / 16'h000A);
          end
          default:
          begin
            dynBrake <= 1'b1;
            coastStop <= 1'b0;
          end
        endcase
      end
    end
  end

  // Speed command ramp, stepped on the ms tick without overshoot
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      speedCmd <= '0;
    else if (instantStop || stopping)
      speedCmd <= '0; // R2
    else if (!speedMode)
      speedCmd <= speedTarget;
    else if (analogSource)
      speedCmd <= SPD_W'(speedScaled); // R7 R15
    else if (tick)
    begin
      if (speedCmd < speedTarget)
        speedCmd <= (speedTarget - speedCmd > SPD_W'(stepUp)) ?
          SPD_W'(speedCmd + SPD_W'(stepUp)) : speedTarget; // R21 R3
      else if (speedCmd > speedTarget)
        speedCmd <= (speedCmd - speedTarget > SPD_W'(stepDn)) ?
          SPD_W'(speedCmd - SPD_W'(stepDn)) : speedTarget; // R21 R4
    end
  end

  // Speed flags with hold; threshold in 0.1 rpm, measured speed in rpm
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      zero_speed_flag <= 1'b0;
      target_speed_reached <= 1'b0;
    end
    else
    begin
      zero_speed_flag <= 32'(speedMag) * 32'h0000_000A <= 32'(zspdQ); // R10 R11
      if (32'(speedMag) >= 32'(tspdQ))
        target_speed_reached <= 1'b1; // R12
      else
        target_speed_reached <= 1'b0; // R13
    end
  end

  // Holding brake sequencing: delay after servo-on and after servo-off
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      brk_q <= BRK_IDLE;
      brkCnt_q <= 16'h0000;
      servoOn_q <= 1'b0;
      holding_brake_output <= 1'b0;
    end
    else
    begin
      // Edge history for the servo-on detector
      servoOn_q <= servoOn;
      unique case (brk_q)
        BRK_IDLE:
          // Only a fresh servo-on starts the on delay, not a held level
          if (servoOn && !servoOn_q)
          begin
            brk_q <= BRK_ON_WAIT;
            brkCnt_q <= 16'h0000;
          end
        BRK_ON_WAIT:
          // Servo-off or alarm before the delay ends aborts with the output low
          if (stopping)
            brk_q <= BRK_IDLE;
          else if (brkCnt_q >= brkOnQ)
          begin
            holding_brake_output <= 1'b1; // R17
            brk_q <= BRK_RUN;
          end
          else if (tick)
            brkCnt_q <= brkCnt_q + 16'h0001;
        BRK_RUN:
          // Alarm and operational stop enter the off delay like servo-off
          if (stopping)
          begin
            brk_q <= BRK_OFF_WAIT;
            brkCnt_q <= 16'h0000;
          end
        BRK_OFF_WAIT:
          // Negative delay is released at once: zero wait is the safe floor
          if (brkOffQ[15] || brkCnt_q >= brkOffQ ||
            32'(speedMag) * 32'h0000_000A < 32'(zspdQ)) // R18 R19 R20
          begin
            holding_brake_output <= 1'b0;
            brk_q <= BRK_IDLE;
          end
          else if (tick)
            brkCnt_q <= brkCnt_q + 16'h0001;
      endcase
    end
  end
endmodule

// ===== testbench/servo_ramp_checker.sv
// Port-level assertions for the servo ramp and brake block
`include "servo_ramp_params.svh"
module servo_ramp_checker
  import servo_ramp_pkg::*;
#(
  parameter int SPD_W = 16
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [9:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdData,
  input wire logic servoOn,
  input wire logic alarmActive,
  input wire logic operational_stop,
  input wire logic analogSource,
  input wire logic signed [SPD_W-1:0] measSpeed,
  input wire logic [7:0] analogTorqueVolt,
  input wire logic [15:0] torqueValue,
  input wire logic [15:0] smoothEff,
  input wire logic dynBrake,
  input wire logic coastStop,
  input wire logic zero_speed_flag,
  input wire logic target_speed_reached,
  input wire logic holding_brake_output
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] thrQ, tspdQ, tslQ, tfsQ;
  logic [31:0] tqExp;
  logic zExp, tExp;
  int mag;
  // Shadow copies of the registers the outputs depend on
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      thrQ <= `RST_ZERO_SPEED_FLAG;
      tspdQ <= `RST_TARGET_SPEED_REACHED;
      tslQ <= `RST_SCURVE;
      tfsQ <= `RST_TFS;
    end
    else if (regWr)
    begin
      if (regAddr == `OFS_ZERO_SPEED_FLAG) thrQ <= regWrData;
      if (regAddr == `OFS_TARGET_SPEED_REACHED) tspdQ <= regWrData;
      if (regAddr == `OFS_SCURVE) tslQ <= regWrData;
      if (regAddr == `OFS_TFS) tfsQ <= regWrData;
    end
  // Threshold is in tenths of rpm, speed in whole rpm
  assign mag = measSpeed < 0 ? -int'(measSpeed) : int'(measSpeed);
  assign zExp = mag * 10 <= int'(thrQ);
  assign tExp = mag >= int'(tspdQ);
  assign tqExp = 32'(analogTorqueVolt) * 32'(tfsQ) / 32'h64;
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_rdHole;
    regRd && regAddr == 10'h3FE;
  endsequence
  // Quiet inputs long enough for the scaling pipeline to settle
  sequence s_tqQuiet;
    (!regWr && $stable(analogTorqueVolt)) [*3];
  endsequence
  property p_rdHole;
    s_rdHole |=> regRdData == 16'h0000;
  endproperty
  a_rdHole: assert property (p_rdHole) else $error("unmapped read not zero");
  property p_zero;
    rst_b |=> zero_speed_flag == $past(zExp);
  endproperty
  a_zero: assert property (p_zero) else $error("zero speed flag wrong");
  property p_target;
    rst_b |=> target_speed_reached == $past(tExp);
  endproperty
  a_target: assert property (p_target) else $error("target flag wrong");
  property p_torque;
    s_tqQuiet |-> torqueValue == tqExp[15:0];
  endproperty
  a_torque: assert property (p_torque) else $error("torque scaling wrong");
  property p_smoothAna;
    analogSource |-> smoothEff == 16'h0000;
  endproperty
  a_smoothAna: assert property (p_smoothAna) else $error("smoothing not forced");
  property p_smooth;
    !analogSource |-> smoothEff == tslQ;
  endproperty
  a_smooth: assert property (p_smooth) else $error("smoothing time wrong");
  property p_stopExcl;
    !(dynBrake && coastStop);
  endproperty
  a_stopExcl: assert property (p_stopExcl) else $error("brake and coast together");
  property p_brkOn;
    $rose(holding_brake_output) |-> $past(servoOn);
  endproperty
  a_brkOn: assert property (p_brkOn) else $error("brake on without servo");
  property p_brkOff;
    $fell(holding_brake_output) |-> !$past(servoOn) || $past(alarmActive) ||
      $past(operational_stop);
  endproperty
  a_brkOff: assert property (p_brkOff) else $error("brake off with servo");
endmodule
bind servo_ramp_brake_status servo_ramp_checker #(.SPD_W(SPD_W)) u_chk (.*);

// ===== testbench/motor_model.sv
// Behavioural motor and speed feedback beside the servo ramp block
module motor_model
#(
  parameter int SPD_W = 16
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic signed [SPD_W-1:0] speedCmd,
  input wire logic dynBrake,
  input wire logic coastStop,
  input wire logic instantStop,
  input wire logic follow,
  input wire logic signed [SPD_W-1:0] setSpeed,
  output logic signed [SPD_W-1:0] measSpeed
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shaft tracks command; shorted winding sheds speed faster than coasting
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      measSpeed <= '0;
    else if (!follow)
      measSpeed <= setSpeed;
    else if (instantStop)
      measSpeed <= '0;
    else if (dynBrake)
      measSpeed <= measSpeed - measSpeed / 4;
    else if (coastStop)
      measSpeed <= measSpeed - measSpeed / 16;
    else
      measSpeed <= speedCmd;
endmodule

// ===== testbench/servo_ramp_brake_status_bench.sv
// Self-checking bench for the servo ramp and brake block
`include "servo_ramp_params.svh"
module servo_ramp_brake_status_bench
  import servo_ramp_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 10;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [9:0] regAddr = '0;
  logic [15:0] regWrData = '0;
  logic regWr = 1'b0, regRd = 1'b0, servoOn = 1'b0, alarmActive = 1'b0;
  logic operational_stop = 1'b0, forward_limit_alarm = 1'b0, reverse_limit_alarm = 1'b0;
  logic speedMode = 1'b0, torqueMode = 1'b0, analogSource = 1'b0, follow = 1'b0;
  logic signed [15:0] speedTarget = '0, setSpeed = '0, speedCmd, measSpeed;
  logic [7:0] analogSpeedVolt = '0, analogTorqueVolt = '0;
  logic [15:0] regRdData, speedLimit, torqueValue, smoothEff;
  logic dynBrake, coastStop, instantStop, zero_speed_flag;
  logic target_speed_reached, holding_brake_output;
  int bad_count = 0;
  int comparisons = 0;
  always #5 sys_clk = ~sys_clk;
  servo_ramp_brake_status #(.MS_CYCLES(MS)) u_servo_ramp_brake_status (.*);
  motor_model motor (.*);
  // Waits, then steps past the edge so its updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("Error %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData === e, "register read");
  endtask
  task automatic t_regs;
    rd(`OFS_ACCEL, 16'h00C8);
    rd(`OFS_DECEL, 16'h00C8);
    rd(`OFS_SCURVE, 16'h0000);
    rd(`OFS_TARGET_SPEED_REACHED, 16'h0BB8);
    rd(`OFS_VFS, 16'h2711);
    rd(`OFS_TFS, 16'h0064);
    rd(`OFS_BRKON, 16'h0000);
    rd(`OFS_BRKOFF, 16'h0000);
    rd(10'h3FE, 16'h0000);
    wr(`OFS_ACCEL, 16'hFFDC);
    rd(`OFS_ACCEL, 16'hFFDC);
    $display("registers done");
  endtask
  task automatic spd(input logic signed [15:0] v, input logic z, input logic t);
    @(posedge sys_clk);
    setSpeed <= v;
    cyc(3);
    chk(zero_speed_flag === z, "zero speed flag");
    chk(target_speed_reached === t, "target reached");
  endtask
  task automatic t_flags;
    spd(16'sh000A, 1'b1, 1'b0);
    spd(16'sh000B, 1'b0, 1'b0);
    spd(-16'sh000A, 1'b1, 1'b0);
    spd(-16'sh0BB8, 1'b0, 1'b1);
    spd(16'sh0BB7, 1'b0, 1'b0);
    wr(`OFS_ZERO_SPEED_FLAG, 16'h0000);
    spd(16'sh0000, 1'b1, 1'b0);
    spd(16'sh0001, 1'b0, 1'b0);
    wr(`OFS_ZERO_SPEED_FLAG, 16'h0064);
    $display("flags done");
  endtask
  // Rated 3000 rpm over 10 ms, then 20 ms down with smoothing
  task automatic t_ramp;
    wr(`OFS_ACCEL, 16'h000A);
    wr(`OFS_DECEL, 16'h000A);
    speedMode <= 1'b1;
    follow <= 1'b1;
    servoOn <= 1'b1;
    speedTarget <= 16'sh0BB8;
    cyc(4 * MS);
    chk(speedCmd > 16'sh0000 && speedCmd < 16'sh0BB8, "ramp up too fast");
    cyc(10 * MS);
    chk(speedCmd === 16'sh0BB8, "ramp end");
    wr(`OFS_SCURVE, 16'h000A);
    speedTarget <= 16'sh0000;
    cyc(12 * MS);
    chk(speedCmd > 16'sh0000, "smoothing ignored");
    cyc(12 * MS);
    chk(speedCmd === 16'sh0000, "ramp down end");
    $display("ramp done");
  endtask
  task automatic t_analog;
    wr(`OFS_VFS, 16'h0BB8);
    analogSource <= 1'b1;
    analogSpeedVolt <= 8'h32;
    analogTorqueVolt <= 8'h32;
    cyc(4);
    chk(speedCmd === 16'sh05DC, "analog speed");
    chk(smoothEff === 16'h0000, "analog smoothing");
    chk(torqueValue === 16'h0032, "analog torque");
    @(posedge sys_clk);
    speedMode <= 1'b0;
    torqueMode <= 1'b1;
    cyc(4);
    chk(speedLimit === 16'h05DC, "analog limit");
    $display("analog done");
  endtask
  task automatic brk(input logic on, input int n, input logic e);
    @(posedge sys_clk);
    servoOn <= on;
    cyc(n);
    chk(holding_brake_output === e, "brake output");
  endtask
  task automatic t_brake;
    wr(`OFS_BRKON, 16'h0005);
    wr(`OFS_BRKOFF, 16'h0005);
    follow <= 1'b0;
    setSpeed <= 16'sh03E8;
    brk(1'b0, 3 * MS, 1'b1);
    cyc(4 * MS);
    chk(holding_brake_output === 1'b0, "brake late off");
    brk(1'b1, 3 * MS, 1'b0);
    cyc(4 * MS);
    chk(holding_brake_output === 1'b1, "brake late on");
    @(posedge sys_clk);
    setSpeed <= 16'sh0000;
    brk(1'b0, 5, 1'b0);
    wr(`OFS_BRKOFF, 16'hFFF6);
    setSpeed <= 16'sh03E8;
    brk(1'b1, 8 * MS, 1'b1);
    brk(1'b0, 5, 1'b0);
    $display("brake done");
  endtask
  task automatic t_stop;
    for (int m = 0; m < 3; m++)
    begin
      wr(`OFS_STOPSEL, 16'(m));
      setSpeed <= 16'sh03E8;
      servoOn <= 1'b1;
      // One-cycle servo-on never outlasts the brake-on delay
      brk(1'b0, 3, 1'b0);
      chk(dynBrake === (m != 1), "dynamic stop");
      chk(coastStop === (m == 1), "coast stop");
    end
    @(posedge sys_clk);
    setSpeed <= 16'sh0000;
    cyc(3);
    chk(coastStop === 1'b1 && dynBrake === 1'b0, "coast after slow");
    wr(`OFS_LIMDEC, 16'h0001);
    servoOn <= 1'b1;
    forward_limit_alarm <= 1'b1;
    cyc(3);
    chk(instantStop === 1'b1, "forward limit");
    @(posedge sys_clk);
    forward_limit_alarm <= 1'b0;
    reverse_limit_alarm <= 1'b1;
    cyc(3);
    chk(instantStop === 1'b1, "reverse limit");
    @(posedge sys_clk);
    reverse_limit_alarm <= 1'b0;
    alarmActive <= 1'b1;
    cyc(3);
    chk(coastStop === 1'b1, "alarm stop");
    @(posedge sys_clk);
    alarmActive <= 1'b0;
    operational_stop <= 1'b1;
    cyc(3);
    chk(coastStop === 1'b1, "operational stop");
    $display("stop done");
  endtask
  task automatic finish_test;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_flags();
    t_ramp();
    t_analog();
    t_brake();
    t_stop();
    finish_test();
  end
  // Whole run needs under a thousand cycles; far beyond that is a hang
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    $display("Error %0t watchdog expired", $time);
    finish_test();
  end
endmodule
